// ---- shared/tic_defs.svh ----
// constants of the time interval counter: offsets, fields, resets and timing
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

`define TIC_ADDR_CTRL   8'ha1
`define TIC_ADDR_FRAC   8'ha2
`define TIC_ADDR_SEC    8'ha3
`define TIC_ADDR_MIN    8'ha4
`define TIC_ADDR_HOUR   8'ha5
`define TIC_ADDR_MATCH  8'ha6

`define TIC_BIT_TIME_EN 0
`define TIC_BIT_IEN     1
`define TIC_BIT_FLAG    2
`define TIC_BIT_SINGLE  3
`define TIC_BIT_SEL_LO  4
`define TIC_BIT_SEL_HI  5

`define TIC_CTRL_RST    8'h00
`define TIC_TOD_RST     8'h00
`define TIC_MATCH_RST   8'h00
`define TIC_RD_IDLE     8'h00

`define TIC_FRAC_MAX    8'h7f
`define TIC_SEC_MAX     8'h3b
`define TIC_MIN_MAX     8'h3b
`define TIC_HOUR_MAX    8'h17

`define TIC_CLK_NS      10
`define TIC_TICK_NS     7812500
`define TIC_TICK_CYC    (`TIC_TICK_NS / `TIC_CLK_NS)

`endif

// ---- shared/tic_pkg.sv ----
// types of the time interval counter
package tic_pkg;

  typedef logic [7:0] tic_byte_t;

  typedef enum logic [1:0] {
    TIC_TB_FRAC,
    TIC_TB_SEC,
    TIC_TB_MIN,
    TIC_TB_HOUR
  } tic_sel_e;

  typedef struct packed {
    tic_sel_e sel;
    logic     single;
    logic     flag;
    logic     ien;
    logic     time_en;
  } tic_ctrl_s;

  typedef struct packed {
    tic_ctrl_s ctrl;
    tic_byte_t match;
    tic_byte_t icnt;
    tic_byte_t rdata;
    logic      irq;
  } tic_state_s;

endpackage : tic_pkg

// ---- shared/tic_if.sv ----
// interfaces between the top and its counter modules
interface tic_cnt_if;
  import tic_pkg::*;
  logic      inc;
  logic      load;
  tic_byte_t load_val;
  tic_byte_t value;
  logic      carry;
  modport ctl (output inc, output load, output load_val, input value, input carry);
  modport cnt (input inc, input load, input load_val, output value, output carry);
endinterface : tic_cnt_if

interface tic_tick_if;
  logic run;
  logic tick;
  modport ctl (output run, input tick);
  modport div (input run, output tick);
endinterface : tic_tick_if

// ---- verilog/tic_prescale.sv ----
// divider that turns the system clock into the 1/128 s tick
module tic_prescale #(
  parameter int unsigned CYCLES = 781250
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // tick
  tic_tick_if.div  tk
);
  localparam int unsigned W = $clog2(CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tic_pre_s;

  tic_pre_s st_ff;
  tic_pre_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!tk.run) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == W'(CYCLES - 1)) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tk.tick = st_ff.tick;

  a_tick_single : assert property (@(posedge clk) disable iff (!rst_n) st_ff.tick |=> !st_ff.tick)
    else $error("divider tick longer than one cycle");
endmodule : tic_prescale

// ---- verilog/tic_wrap_cnt.sv ----
// one time-of-day register: loadable counter that wraps at its maximum
`include "tic_defs.svh"
module tic_wrap_cnt #(
  parameter tic_pkg::tic_byte_t MAX = 8'hff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // counter port
  tic_cnt_if.cnt   c
);
  import tic_pkg::*;

  typedef struct packed {
    tic_byte_t value;
  } tic_wrap_s;

  tic_wrap_s st_ff;
  tic_wrap_s nxt_st;

  // >= so that an out-of-range preset still wraps instead of running to 255
  assign c.carry = c.inc && (st_ff.value >= MAX);

  always_comb begin
    nxt_st = st_ff;
    if (c.load) begin
      nxt_st.value = c.load_val;
    end else if (c.carry) begin
      nxt_st.value = `TIC_TOD_RST;
    end else if (c.inc) begin
      nxt_st.value = st_ff.value + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff.value <= `TIC_TOD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign c.value = st_ff.value;

  a_wrap_zero : assert property (@(posedge clk) disable iff (!rst_n)
    c.inc && !c.load && st_ff.value == MAX |=> st_ff.value == 8'h00)
    else $error("time register did not wrap to zero");
endmodule : tic_wrap_cnt

// ---- verilog/tic_top.sv ----
// time interval counter: time-of-day registers, interval counter and register port
`include "tic_defs.svh"

module tic_top #(
  parameter int unsigned TICK_CYCLES = `TIC_TICK_CYC
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // register port
  input  wire tic_pkg::tic_byte_t addr,
  input  wire tic_pkg::tic_byte_t wdata,
  input  wire logic         wr_stb,
  input  wire logic         rd_stb,
  output tic_pkg::tic_byte_t rdata_ff,
  // interrupt
  input  wire logic         intr_enable,
  output logic              intr_req_ff
);
  import tic_pkg::*;

  tic_state_s st_ff;
  tic_state_s nxt_st;

  tic_tick_if tick_if ();
  tic_cnt_if  frac_if ();
  tic_cnt_if  sec_if ();
  tic_cnt_if  min_if ();
  tic_cnt_if  hour_if ();

  logic      wr_ctrl;
  logic      wr_time;
  logic      sel_tick;
  logic      ivl_tick;
  logic      ivl_hit;
  tic_byte_t icnt_inc;

  // divider and time-of-day chain

  tic_prescale #(
    .CYCLES (TICK_CYCLES)
  ) u_prescale (
    .clk   (clk),
    .rst_n (rst_n),
    .tk    (tick_if.div)
  );

  tic_wrap_cnt #(
    .MAX (`TIC_FRAC_MAX)
  ) u_frac (
    .clk   (clk),
    .rst_n (rst_n),
    .c     (frac_if.cnt)
  );

  tic_wrap_cnt #(
    .MAX (`TIC_SEC_MAX)
  ) u_sec (
    .clk   (clk),
    .rst_n (rst_n),
    .c     (sec_if.cnt)
  );

  tic_wrap_cnt #(
    .MAX (`TIC_MIN_MAX)
  ) u_min (
    .clk   (clk),
    .rst_n (rst_n),
    .c     (min_if.cnt)
  );

  tic_wrap_cnt #(
    .MAX (`TIC_HOUR_MAX)
  ) u_hour (
    .clk   (clk),
    .rst_n (rst_n),
    .c     (hour_if.cnt)
  );

  // divider is held in reset while the time clock is off
  assign tick_if.run = st_ff.ctrl.time_en;

  assign wr_ctrl = wr_stb && (addr == `TIC_ADDR_CTRL);
  // presets only land while the time clock is stopped, so load never meets inc
  assign wr_time = wr_stb && !st_ff.ctrl.time_en;

  assign frac_if.inc      = tick_if.tick && st_ff.ctrl.time_en;
  assign frac_if.load     = wr_time && (addr == `TIC_ADDR_FRAC);
  assign frac_if.load_val = wdata;
  assign sec_if.inc       = frac_if.carry;
  assign sec_if.load      = wr_time && (addr == `TIC_ADDR_SEC);
  assign sec_if.load_val  = wdata;
  assign min_if.inc       = sec_if.carry;
  assign min_if.load      = wr_time && (addr == `TIC_ADDR_MIN);
  assign min_if.load_val  = wdata;
  assign hour_if.inc      = min_if.carry;
  assign hour_if.load     = wr_time && (addr == `TIC_ADDR_HOUR);
  assign hour_if.load_val = wdata;

  // interval timebase choice
  always_comb begin
    case (st_ff.ctrl.sel)
      TIC_TB_FRAC: sel_tick = frac_if.inc;
      TIC_TB_SEC:  sel_tick = frac_if.carry;
      TIC_TB_MIN:  sel_tick = sec_if.carry;
      TIC_TB_HOUR: sel_tick = min_if.carry;
      default:     sel_tick = 1'b0;
    endcase
  end

  assign ivl_tick = sel_tick && st_ff.ctrl.time_en && st_ff.ctrl.ien;
  assign icnt_inc = st_ff.icnt + 8'h01;
  // compare on the stepped value, so a match of 0 needs 256 steps
  assign ivl_hit  = ivl_tick && (icnt_inc == st_ff.match);

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = `TIC_RD_IDLE;
    // the request lags the flag by a cycle; the enable lives outside
    nxt_st.irq   = st_ff.ctrl.flag && intr_enable;
    if (wr_ctrl) begin
      nxt_st.ctrl.sel    = tic_sel_e'(wdata[`TIC_BIT_SEL_HI:`TIC_BIT_SEL_LO]);
      nxt_st.ctrl.single = wdata[`TIC_BIT_SINGLE];
      nxt_st.ctrl.ien    = wdata[`TIC_BIT_IEN];
      nxt_st.ctrl.time_en = wdata[`TIC_BIT_TIME_EN];
      if (!wdata[`TIC_BIT_FLAG]) begin
        nxt_st.ctrl.flag = 1'b0;
      end
    end
    if (wr_stb && addr == `TIC_ADDR_MATCH) begin
      nxt_st.match = wdata;
    end
    if (ivl_tick) begin
      nxt_st.icnt = icnt_inc;
    end
    if (ivl_hit) begin
      nxt_st.ctrl.flag = 1'b1;
      nxt_st.icnt      = 8'h00;
      if (st_ff.ctrl.single) begin
        nxt_st.ctrl.ien = 1'b0;
      end
    end
    if (!nxt_st.ctrl.ien || !nxt_st.ctrl.time_en) begin
      nxt_st.icnt = 8'h00;
    end
    if (rd_stb) begin
      case (addr)
        `TIC_ADDR_CTRL:  nxt_st.rdata = {2'b00, st_ff.ctrl};
        `TIC_ADDR_FRAC:  nxt_st.rdata = frac_if.value;
        `TIC_ADDR_SEC:   nxt_st.rdata = sec_if.value;
        `TIC_ADDR_MIN:   nxt_st.rdata = min_if.value;
        `TIC_ADDR_HOUR:  nxt_st.rdata = hour_if.value;
        `TIC_ADDR_MATCH: nxt_st.rdata = st_ff.match;
        default:         nxt_st.rdata = `TIC_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff.ctrl  <= tic_ctrl_s'(6'(`TIC_CTRL_RST));
      st_ff.match <= `TIC_MATCH_RST;
      st_ff.icnt  <= 8'h00;
      st_ff.rdata <= `TIC_RD_IDLE;
      st_ff.irq   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_ff    = st_ff.rdata;
  assign intr_req_ff = st_ff.irq;

  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_flag_sticky : assert property (
    st_ff.ctrl.flag && !(wr_ctrl && !wdata[`TIC_BIT_FLAG]) |=> st_ff.ctrl.flag)
    else $error("interval flag dropped without a software clear");

  a_flag_on_match : assert property (
    ivl_tick && (st_ff.icnt + 8'h01 == st_ff.match) |=> st_ff.ctrl.flag)
    else $error("interval flag not set on match");

  a_flag_clear_sw : assert property (
    wr_ctrl && !wdata[`TIC_BIT_FLAG] && !ivl_hit |=> !st_ff.ctrl.flag)
    else $error("software clear of interval flag lost");

  a_single_stop : assert property (
    ivl_hit && st_ff.ctrl.single && !wr_ctrl |=> !st_ff.ctrl.ien && st_ff.icnt == 8'h00)
    else $error("single interval did not stop the counter");

  a_reload_run : assert property (
    ivl_hit && !st_ff.ctrl.single && !wr_ctrl |=> st_ff.ctrl.ien && st_ff.icnt == 8'h00)
    else $error("auto reload did not restart from zero");

  a_ien_clear : assert property (
    !st_ff.ctrl.ien |-> st_ff.icnt == 8'h00)
    else $error("interval count nonzero while disabled");

  a_timeoff_clear : assert property (
    !st_ff.ctrl.time_en && !wr_ctrl |=> st_ff.icnt == 8'h00 && !u_prescale.st_ff.tick)
    else $error("interval logic still running with time clock off");

  a_time_hold : assert property (
    !st_ff.ctrl.time_en && !wr_stb |=> $stable(frac_if.value) && $stable(sec_if.value))
    else $error("time registers moved with time clock off");

  a_time_preset : assert property (
    wr_stb && !st_ff.ctrl.time_en && addr == `TIC_ADDR_SEC |=> sec_if.value == $past(wdata))
    else $error("seconds preset not taken");

  a_frac_step : assert property (
    ivl_tick && st_ff.ctrl.sel == TIC_TB_FRAC && !ivl_hit && !wr_ctrl
      |=> st_ff.icnt == $past(st_ff.icnt) + 8'h01)
    else $error("interval count did not step on selected tick");

  a_sec_only : assert property (
    st_ff.ctrl.sel == TIC_TB_SEC && !frac_if.carry && !wr_ctrl && st_ff.ctrl.ien
      |=> st_ff.icnt == $past(st_ff.icnt))
    else $error("interval count stepped without a seconds overflow");

  a_irq_follow : assert property (
    st_ff.ctrl.flag && intr_enable |=> intr_req_ff)
    else $error("interrupt request missing for set flag");

  a_irq_drop : assert property (
    !intr_enable |=> !intr_req_ff)
    else $error("interrupt request while interrupt disabled");

  a_read_pulse : assert property (
    !rd_stb |=> rdata_ff == 8'h00)
    else $error("read data outside read answer cycle");

  c_single_shot : cover property (ivl_hit && st_ff.ctrl.single);
  c_auto_reload : cover property (ivl_hit && !st_ff.ctrl.single ##1 ivl_tick);
  c_hour_wrap   : cover property (hour_if.carry);
  c_flag_clear  : cover property (st_ff.ctrl.flag ##1 !st_ff.ctrl.flag);

endmodule : tic_top

// ---- verification/test_time_interval_counter.sv ----
// self-checking bench of the time interval counter
`include "tic_defs.svh"

module test_time_interval_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import tic_pkg::*;

  // short tick keeps the run small
  localparam int unsigned TK = 4;

  logic      clk;
  logic      rst_n;
  logic      wr_stb;
  logic      rd_stb;
  logic      intr_enable;
  logic      intr_req_ff;
  logic      hit;
  tic_byte_t addr;
  tic_byte_t wdata;
  tic_byte_t rdata_ff;
  tic_byte_t rd_val;
  int        n_errors;
  int        tests_run;

  tic_top #(.TICK_CYCLES(TK)) u_dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .addr       (addr),
    .wdata      (wdata),
    .wr_stb     (wr_stb),
    .rd_stb     (rd_stb),
    .rdata_ff   (rdata_ff),
    .intr_enable(intr_enable),
    .intr_req_ff(intr_req_ff)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check

  task automatic wr(input tic_byte_t a, input tic_byte_t d);
    @(posedge clk);
    addr   <= a;
    wdata  <= (a == `TIC_ADDR_CTRL) ? (d | 8'h40) : d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input tic_byte_t a);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 rd_val = rdata_ff;
  endtask : rd

  // bounded wait on the flag, two cycles per look
  task automatic poll(input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      rd(`TIC_ADDR_CTRL);
      hit = (rd_val[2] === 1'b1);
    end
  endtask : poll

  task automatic t_reset;
    for (int a = 8'ha1; a <= 8'ha6; a++) begin
      rd(a[7:0]);
      check(rd_val === 8'h00, "register not zero after reset");
    end
    wr(8'h10, 8'h55);
    rd(8'h10);
    check(rd_val === 8'h00, "unmapped read not zero");
    wr(`TIC_ADDR_CTRL, 8'hc0);
    rd(`TIC_ADDR_CTRL);
    check(rd_val === 8'h00, "reserved control bits read back");
  endtask : t_reset

  task automatic t_roll;
    tic_byte_t f0;
    wr(`TIC_ADDR_FRAC, 8'h7f);
    wr(`TIC_ADDR_SEC, 8'h3b);
    wr(`TIC_ADDR_MIN, 8'h3b);
    wr(`TIC_ADDR_HOUR, 8'h17);
    rd(`TIC_ADDR_HOUR);
    check(rd_val === 8'h17, "hour preset lost");
    wr(`TIC_ADDR_CTRL, 8'h01);
    wr(`TIC_ADDR_SEC, 8'h05);
    hit = 1'b0;
    for (int i = 0; i < 10 && !hit; i++) begin
      rd(`TIC_ADDR_HOUR);
      hit = (rd_val === 8'h00);
    end
    check(hit, "hour did not wrap");
    wr(`TIC_ADDR_CTRL, 8'h00);
    rd(`TIC_ADDR_SEC);
    check(rd_val === 8'h00, "seconds wrong after wrap or write taken while running");
    rd(`TIC_ADDR_MIN);
    check(rd_val === 8'h00, "minutes did not wrap");
    rd(`TIC_ADDR_FRAC);
    check(rd_val < 8'h05, "fraction did not wrap");
    f0 = rd_val;
    repeat (20) @(posedge clk);
    rd(`TIC_ADDR_FRAC);
    check(rd_val === f0, "time advanced with clock disabled");
  endtask : t_roll

  // armed preset steps the selected register on the first tick
  task automatic t_sel;
    for (int s = 0; s < 4; s++) begin
      wr(`TIC_ADDR_CTRL, 8'h00);
      wr(`TIC_ADDR_FRAC, 8'h7f);
      wr(`TIC_ADDR_SEC, (s >= 2) ? 8'h3b : 8'h00);
      wr(`TIC_ADDR_MIN, (s >= 3) ? 8'h3b : 8'h00);
      wr(`TIC_ADDR_MATCH, 8'h01);
      wr(`TIC_ADDR_CTRL, {2'b00, s[1:0], 4'b0011});
      poll(8);
      check(hit, "selected overflow did not step count");
      wr(`TIC_ADDR_CTRL, 8'h00);
      wr(`TIC_ADDR_FRAC, 8'h00);
      wr(`TIC_ADDR_SEC, 8'h00);
      wr(`TIC_ADDR_MIN, 8'h00);
      wr(`TIC_ADDR_CTRL, {2'b00, s[1:0], 4'b0011});
      poll(8);
      check(hit === (s == 0), "wrong timebase stepped count");
    end
  endtask : t_sel

  task automatic t_auto;
    wr(`TIC_ADDR_CTRL, 8'h00);
    wr(`TIC_ADDR_MATCH, 8'h03);
    wr(`TIC_ADDR_CTRL, 8'h03);
    poll(12);
    check(hit, "no flag on match");
    check(rd_val[1] === 1'b1, "enable lost in reload mode");
    check(intr_req_ff === 1'b0, "request while masked");
    @(posedge clk);
    intr_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(intr_req_ff === 1'b1, "no request while enabled");
    // puts the clear between two reload timeouts; a timeout in the same cycle wins
    repeat (41) @(posedge clk);
    rd(`TIC_ADDR_CTRL);
    check(rd_val[2] === 1'b1, "flag cleared by hardware");
    wr(`TIC_ADDR_CTRL, 8'h03);
    rd(`TIC_ADDR_CTRL);
    check(rd_val[2] === 1'b0, "flag not cleared by software");
    poll(12);
    check(hit, "no second timeout after reload");
    @(posedge clk);
    intr_enable <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(intr_req_ff === 1'b0, "request kept after disable");
  endtask : t_auto

  task automatic t_single;
    wr(`TIC_ADDR_CTRL, 8'h00);
    wr(`TIC_ADDR_MATCH, 8'h02);
    wr(`TIC_ADDR_CTRL, 8'h0b);
    poll(12);
    check(hit, "no single timeout");
    check(rd_val[1] === 1'b0, "enable kept after single timeout");
    wr(`TIC_ADDR_CTRL, 8'h09);
    repeat (40) @(posedge clk);
    rd(`TIC_ADDR_CTRL);
    check(rd_val[2] === 1'b0, "counter ran on after single timeout");
  endtask : t_single

  // a cleared count needs all five ticks again
  task automatic t_clear(input int b);
    wr(`TIC_ADDR_CTRL, 8'h00);
    wr(`TIC_ADDR_MATCH, 8'h05);
    wr(`TIC_ADDR_CTRL, 8'h03);
    repeat (12) @(posedge clk);
    wr(`TIC_ADDR_CTRL, 8'h03 & ~(8'h01 << b));
    wr(`TIC_ADDR_CTRL, 8'h03);
    poll(6);
    check(hit === 1'b0, "count kept across disable");
  endtask : t_clear

  task automatic print_verdict;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    #100us;
    n_errors++;
    $display("FAIL %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr_stb      = 1'b0;
    rd_stb      = 1'b0;
    intr_enable = 1'b0;
    n_errors    = 0;
    tests_run   = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_roll();
    t_sel();
    t_auto();
    t_single();
    t_clear(1);
    t_clear(0);
    print_verdict();
  end

endmodule : test_time_interval_counter
